//--- src/flash_cmd_defines.svh
// command codes, unlock addresses and bus timing counts for the flash host controller
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH
`define CMD_UNLOCK1 8'haa
`define CMD_UNLOCK2 8'h55
`define CMD_RESET 8'hf0
`define CMD_PROGRAM 8'ha0
`define CMD_AUTOSEL 8'h90
`define CMD_SECURED 8'h88
`define CMD_BYPASS 8'h20
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30
`define CMD_CFI 8'h98
`define CMD_EXIT 8'h00
`define ADDR_W_UNLOCK1 22'h000555
`define ADDR_W_UNLOCK2 22'h0002aa
`define ADDR_B_UNLOCK1 22'h000aaa
`define ADDR_B_UNLOCK2 22'h000555
`define ADDR_W_CFI 22'h000055
`define ADDR_B_CFI 22'h0000aa
`define BANK_MSB 21
`define BANK_LSB 19
`define SECT_LSB 12
`define OFS_W_MANUF 22'h000000
`define OFS_W_DEVID1 22'h000001
`define OFS_W_DEVID2 22'h00000e
`define OFS_W_DEVID3 22'h00000f
`define OFS_W_FACTLOCK 22'h000003
`define OFS_W_SECTPROT 22'h000002
`define OFS_B_MANUF 22'h000000
`define OFS_B_DEVID1 22'h000002
`define OFS_B_DEVID2 22'h00001c
`define OFS_B_DEVID3 22'h00001e
`define OFS_B_FACTLOCK 22'h000006
`define OFS_B_SECTPROT 22'h000004
// strobe phases in ref_clk cycles: setup, strobe low, hold
`define T_SETUP 4'h2
`define T_STROBE 4'h7
`define T_HOLD 4'h2
`endif

//--- src/flash_cmd_pkg.sv
// types shared by the flash host controller modules
package flash_cmd_pkg;
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_PROGRAM = 4'h2, OP_BYPASS_ENTER = 4'h3,
    OP_BYPASS_PROGRAM = 4'h4, OP_BYPASS_EXIT = 4'h5, OP_CHIP_ERASE = 4'h6,
    OP_SECTOR_ERASE = 4'h7, OP_SUSPEND = 4'h8, OP_RESUME = 4'h9, OP_AUTOSEL_READ = 4'ha,
    OP_SECURED_ENTER = 4'hb, OP_SECURED_EXIT = 4'hc, OP_CFI = 4'hd
  } op_t;
  typedef enum logic [1:0] {
    ID_MANUF = 2'h0, ID_DEVICE = 2'h1, ID_FACTLOCK = 2'h2, ID_SECTPROT = 2'h3
  } id_sel_t;
  typedef enum logic [1:0] {
    CYC_IDLE = 2'h0, CYC_SETUP = 2'h1, CYC_STROBE = 2'h2, CYC_HOLD = 2'h3
  } cyc_t;
endpackage : flash_cmd_pkg

//--- src/bus_cycle_if.sv
// one flash bus cycle request and its completion
`timescale 1ns/1ps
interface bus_cycle_if;
  logic start;
  logic isWrite;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output start, output isWrite, output addr, output wdata, input done, input rdata);
  modport eng (input start, input isWrite, input addr, input wdata, output done, output rdata);
endinterface : bus_cycle_if

//--- src/bus_cycle_engine.sv
// drives one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module bus_cycle_engine (
  input wire logic ref_clk,
  input wire logic rst_n,
  bus_cycle_if.eng cyc,
  input wire logic [15:0] dqIn,
  output logic [21:0] addrQ,
  output logic [15:0] dqOutQ,
  output logic dqOeQ,
  output logic chipSelN_q,
  output logic writeEnN_q,
  output logic outEnN_q
);
  flash_cmd_pkg::cyc_t phase_q;
  logic [3:0] cnt_q;
  logic wr_q;
  logic done_q;
  logic [15:0] rdata_q;
  logic strobeOn;
  assign cyc.done = done_q;
  assign cyc.rdata = rdata_q;
  assign strobeOn = (phase_q == flash_cmd_pkg::CYC_SETUP && cnt_q == 4'h1) ||
                    (phase_q == flash_cmd_pkg::CYC_STROBE && cnt_q != 4'h1);

  // ----
  // phase sequencing
  // ----
  // select and strobe fall together, so address latches at that edge
  // strobes rise together before data is released
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= flash_cmd_pkg::CYC_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      addrQ <= 22'h000000;
      dqOutQ <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      case (phase_q)
        flash_cmd_pkg::CYC_IDLE: begin
          if (cyc.start) begin
            addrQ <= cyc.addr;
            dqOutQ <= cyc.wdata;
            wr_q <= cyc.isWrite;
            cnt_q <= `T_SETUP;
            phase_q <= flash_cmd_pkg::CYC_SETUP;
          end
        end
        flash_cmd_pkg::CYC_SETUP: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            cnt_q <= `T_STROBE;
            phase_q <= flash_cmd_pkg::CYC_STROBE;
          end
        end
        flash_cmd_pkg::CYC_STROBE: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            cnt_q <= `T_HOLD;
            phase_q <= flash_cmd_pkg::CYC_HOLD;
          end
        end
        flash_cmd_pkg::CYC_HOLD: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            done_q <= 1'b1;
            phase_q <= flash_cmd_pkg::CYC_IDLE;
          end
        end
        default: phase_q <= flash_cmd_pkg::CYC_IDLE;
      endcase
    end
  end

  // ----
  // pin drive
  // ----
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chipSelN_q <= 1'b1;
      writeEnN_q <= 1'b1;
      outEnN_q <= 1'b1;
      dqOeQ <= 1'b0;
    end else begin
      chipSelN_q <= !strobeOn;
      writeEnN_q <= !(wr_q && strobeOn);
      outEnN_q <= !(!wr_q && strobeOn);
      // data held through the hold phase, past the rising strobe
      dqOeQ <= wr_q && phase_q != flash_cmd_pkg::CYC_IDLE &&
               !(phase_q == flash_cmd_pkg::CYC_HOLD && cnt_q == 4'h1);
    end
  end

  // read data sampled on the last strobe cycle, before OE rises
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (!wr_q && phase_q == flash_cmd_pkg::CYC_STROBE && cnt_q == 4'h1) begin
      rdata_q <= dqIn;
    end
  end
endmodule : bus_cycle_engine

//--- src/cycle_list.sv
// builds the address/data/direction of each cycle of a command sequence
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module cycle_list (
  input wire flash_cmd_pkg::op_t op,
  input wire flash_cmd_pkg::id_sel_t idSel,
  input wire logic byteMode,
  input wire logic [2:0] idx,
  input wire logic [21:0] userAddr,
  input wire logic [15:0] userData,
  output logic [21:0] cycAddr,
  output logic [15:0] cycData,
  output logic cycWrite,
  output logic [2:0] cycCount
);
  logic [21:0] u1;
  logic [21:0] u2;
  logic [21:0] bankBase;
  logic [21:0] sectBase;
  logic [7:0] third;
  assign u1 = byteMode ? `ADDR_B_UNLOCK1 : `ADDR_W_UNLOCK1;
  assign u2 = byteMode ? `ADDR_B_UNLOCK2 : `ADDR_W_UNLOCK2;
  // bank from top bits, sector from bits 21..12
  assign bankBase = {userAddr[`BANK_MSB:`BANK_LSB], 19'h00000};
  assign sectBase = {userAddr[`BANK_MSB:`SECT_LSB], 12'h000};

  function automatic logic [21:0] idOffset(input flash_cmd_pkg::id_sel_t s, input logic b, input logic [2:0] i);
    case (s)
      flash_cmd_pkg::ID_DEVICE: begin
        if (i == 3'h3) idOffset = b ? `OFS_B_DEVID1 : `OFS_W_DEVID1;
        else if (i == 3'h4) idOffset = b ? `OFS_B_DEVID2 : `OFS_W_DEVID2;
        else idOffset = b ? `OFS_B_DEVID3 : `OFS_W_DEVID3;
      end
      flash_cmd_pkg::ID_FACTLOCK: idOffset = b ? `OFS_B_FACTLOCK : `OFS_W_FACTLOCK;
      flash_cmd_pkg::ID_SECTPROT: idOffset = b ? `OFS_B_SECTPROT : `OFS_W_SECTPROT;
      default: idOffset = b ? `OFS_B_MANUF : `OFS_W_MANUF;
    endcase
  endfunction : idOffset

  always_comb begin
    case (op)
      flash_cmd_pkg::OP_PROGRAM: third = `CMD_PROGRAM;
      flash_cmd_pkg::OP_BYPASS_ENTER: third = `CMD_BYPASS;
      flash_cmd_pkg::OP_SECURED_ENTER: third = `CMD_SECURED;
      flash_cmd_pkg::OP_CHIP_ERASE, flash_cmd_pkg::OP_SECTOR_ERASE: third = `CMD_ERASE_SETUP;
      default: third = `CMD_AUTOSEL;
    endcase
  end

  // upper data byte zero on command cycles unlocks only in low address
  always_comb begin
    cycAddr = u1;
    cycData = {8'h00, `CMD_UNLOCK1};
    cycWrite = 1'b1;
    cycCount = 3'h1;
    case (op)
      flash_cmd_pkg::OP_READ: begin
        cycAddr = userAddr;
        cycWrite = 1'b0;
      end
      flash_cmd_pkg::OP_RESET: begin
        cycAddr = userAddr;
        cycData = {8'h00, `CMD_RESET};
      end
      flash_cmd_pkg::OP_CFI: begin
        cycAddr = byteMode ? `ADDR_B_CFI : `ADDR_W_CFI;
        cycData = {8'h00, `CMD_CFI};
      end
      flash_cmd_pkg::OP_SUSPEND: begin
        cycAddr = bankBase;
        cycData = {8'h00, `CMD_SUSPEND};
      end
      flash_cmd_pkg::OP_RESUME: begin
        cycAddr = bankBase;
        cycData = {8'h00, `CMD_RESUME};
      end
      flash_cmd_pkg::OP_BYPASS_PROGRAM: begin
        cycCount = 3'h2;
        cycAddr = userAddr;
        cycData = idx == 3'h0 ? {8'h00, `CMD_PROGRAM} : userData;
      end
      flash_cmd_pkg::OP_BYPASS_EXIT: begin
        cycCount = 3'h2;
        cycAddr = idx == 3'h0 ? bankBase : userAddr;
        cycData = idx == 3'h0 ? {8'h00, `CMD_AUTOSEL} : {8'h00, `CMD_EXIT};
      end
      default: begin
        // unlock-prefixed sequences
        case (op)
          flash_cmd_pkg::OP_BYPASS_ENTER, flash_cmd_pkg::OP_SECURED_ENTER: cycCount = 3'h3;
          flash_cmd_pkg::OP_CHIP_ERASE, flash_cmd_pkg::OP_SECTOR_ERASE: cycCount = 3'h6;
          flash_cmd_pkg::OP_AUTOSEL_READ: cycCount = idSel == flash_cmd_pkg::ID_DEVICE ? 3'h6 : 3'h4;
          default: cycCount = 3'h4;
        endcase
        case (idx)
          3'h0, 3'h3: begin
            cycAddr = u1;
            cycData = {8'h00, `CMD_UNLOCK1};
          end
          3'h1, 3'h4: begin
            cycAddr = u2;
            cycData = {8'h00, `CMD_UNLOCK2};
          end
          default: begin
            cycAddr = u1;
            cycData = {8'h00, third};
          end
        endcase
        if (op == flash_cmd_pkg::OP_AUTOSEL_READ && idx == 3'h2) begin
          cycAddr = bankBase | u1;
        end
        if (op == flash_cmd_pkg::OP_AUTOSEL_READ && idx >= 3'h3) begin
          cycWrite = 1'b0;
          cycAddr = (idSel == flash_cmd_pkg::ID_SECTPROT ? sectBase : bankBase) | idOffset(idSel, byteMode, idx);
        end
        if (op == flash_cmd_pkg::OP_PROGRAM && idx == 3'h3) begin
          cycAddr = userAddr;
          cycData = userData;
        end
        if (op == flash_cmd_pkg::OP_SECURED_EXIT && idx == 3'h3) begin
          cycAddr = userAddr;
          cycData = {8'h00, `CMD_EXIT};
        end
        if (idx == 3'h5 && op != flash_cmd_pkg::OP_AUTOSEL_READ) begin
          cycAddr = op == flash_cmd_pkg::OP_SECTOR_ERASE ? sectBase : u1;
          cycData = {8'h00, op == flash_cmd_pkg::OP_SECTOR_ERASE ? `CMD_SECTOR_ERASE : `CMD_CHIP_ERASE};
        end
      end
    endcase
  end
endmodule : cycle_list

//--- src/flash_bus_command_decoder.sv
// host controller issuing command sequences to a multi-bank parallel NOR flash
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module flash_bus_command_decoder (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire flash_cmd_pkg::op_t reqOp,
  input wire flash_cmd_pkg::id_sel_t reqIdSel,
  input wire logic [21:0] reqAddr,
  input wire logic [15:0] reqData,
  input wire logic byteMode,
  output logic reqReady_q,
  output logic rspValid_q,
  output logic [15:0] rspData0_q,
  output logic [15:0] rspData1_q,
  output logic [15:0] rspData2_q,
  output logic bypassActive_q,
  output logic securedActive_q,
  output logic suspended_q,
  output logic [21:0] flashAddr,
  input wire logic [15:0] flashDqIn,
  output logic [15:0] flashDqOut,
  output logic flashDqOe,
  output logic flashCeN,
  output logic flashWeN,
  output logic flashOeN
);
  bus_cycle_if cycBus ();
  flash_cmd_pkg::op_t op_q;
  flash_cmd_pkg::id_sel_t idSel_q;
  logic [21:0] addr_q;
  logic [15:0] data_q;
  logic [2:0] idx_q;
  logic busy_q;
  logic issued_q;
  logic [21:0] cycAddr;
  logic [15:0] cycData;
  logic cycWrite;
  logic [2:0] cycCount;
  logic sectorErase_q;
  logic accept;

  // ----
  // sequence table and pin engine
  // ----
  cycle_list seqTable (
    .op(op_q),
    .idSel(idSel_q),
    .byteMode(byteMode),
    .idx(idx_q),
    .userAddr(addr_q),
    .userData(data_q),
    .cycAddr(cycAddr),
    .cycData(cycData),
    .cycWrite(cycWrite),
    .cycCount(cycCount)
  );

  bus_cycle_engine pins (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cyc(cycBus),
    .dqIn(flashDqIn),
    .addrQ(flashAddr),
    .dqOutQ(flashDqOut),
    .dqOeQ(flashDqOe),
    .chipSelN_q(flashCeN),
    .writeEnN_q(flashWeN),
    .outEnN_q(flashOeN)
  );

  assign cycBus.start = busy_q && !issued_q;
  assign cycBus.isWrite = cycWrite;
  assign cycBus.addr = cycAddr;
  assign cycBus.wdata = cycData;

  // ----
  // request legality
  // ----
  // sequences the flash would ignore or misread are refused here rather than sent, so the
  // flash holds no half-entered sequence, except after an id read sent in secured mode (its exit prefix is left open)
  function automatic logic legal(input flash_cmd_pkg::op_t o, input logic byp, input logic sec,
                                 input logic susp, input logic serase);
    case (o)
      flash_cmd_pkg::OP_BYPASS_PROGRAM, flash_cmd_pkg::OP_BYPASS_EXIT: legal = byp;
      flash_cmd_pkg::OP_SUSPEND: legal = serase && !susp;
      flash_cmd_pkg::OP_RESUME: legal = susp;
      flash_cmd_pkg::OP_SECURED_EXIT: legal = sec && !byp;
      flash_cmd_pkg::OP_CFI: legal = !byp && !serase;
      flash_cmd_pkg::OP_CHIP_ERASE, flash_cmd_pkg::OP_SECTOR_ERASE: legal = !byp && !susp;
      flash_cmd_pkg::OP_READ, flash_cmd_pkg::OP_RESET: legal = 1'b1;
      default: legal = !byp && !(serase && !susp);
    endcase
  endfunction : legal

  assign accept = reqValid && reqReady_q &&
                  legal(reqOp, bypassActive_q, securedActive_q, suspended_q, sectorErase_q);

  // ----
  // sequence walker
  // ----
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= flash_cmd_pkg::OP_READ;
      idSel_q <= flash_cmd_pkg::ID_MANUF;
      addr_q <= 22'h000000;
      data_q <= 16'h0000;
      idx_q <= 3'h0;
      busy_q <= 1'b0;
      issued_q <= 1'b0;
      reqReady_q <= 1'b0;
    end else begin
      if (!busy_q) begin
        reqReady_q <= 1'b1;
        if (accept) begin
          op_q <= reqOp;
          idSel_q <= reqIdSel;
          addr_q <= reqAddr;
          data_q <= reqData;
          idx_q <= 3'h0;
          busy_q <= 1'b1;
          reqReady_q <= 1'b0;
        end
      end else if (!issued_q) begin
        issued_q <= 1'b1;
      end else if (cycBus.done) begin
        issued_q <= 1'b0;
        if (idx_q + 3'h1 == cycCount) begin
          busy_q <= 1'b0;
        end else begin
          idx_q <= idx_q + 3'h1;
        end
      end
    end
  end

  // ----
  // read results
  // ----
  // device id spans cycles 3..5 and all three are captured
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rspValid_q <= 1'b0;
      rspData0_q <= 16'h0000;
      rspData1_q <= 16'h0000;
      rspData2_q <= 16'h0000;
    end else begin
      rspValid_q <= busy_q && issued_q && cycBus.done && idx_q + 3'h1 == cycCount;
      if (busy_q && issued_q && cycBus.done && !cycWrite) begin
        if (op_q == flash_cmd_pkg::OP_READ || idx_q == 3'h3) begin
          // lock and protection answers occupy the low byte only
          rspData0_q <= op_q == flash_cmd_pkg::OP_READ ? cycBus.rdata : {8'h00, cycBus.rdata[7:0]};
        end
        if (idx_q == 3'h4) begin
          rspData1_q <= {8'h00, cycBus.rdata[7:0]};
        end
        if (idx_q == 3'h5) begin
          rspData2_q <= {8'h00, cycBus.rdata[7:0]};
        end
      end
    end
  end

  // ----
  // mode tracking of the far device
  // ----
  // updated when the final cycle completes; identification entered by the read op is
  // left again by the trailing reset the user must send
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bypassActive_q <= 1'b0;
      securedActive_q <= 1'b0;
      suspended_q <= 1'b0;
      sectorErase_q <= 1'b0;
    end else if (busy_q && issued_q && cycBus.done && idx_q + 3'h1 == cycCount) begin
      case (op_q)
        flash_cmd_pkg::OP_BYPASS_ENTER: bypassActive_q <= 1'b1;
        flash_cmd_pkg::OP_BYPASS_EXIT: bypassActive_q <= 1'b0;
        flash_cmd_pkg::OP_SECURED_ENTER: securedActive_q <= 1'b1;
        flash_cmd_pkg::OP_SECURED_EXIT: securedActive_q <= 1'b0;
        flash_cmd_pkg::OP_SECTOR_ERASE: sectorErase_q <= 1'b1;
        flash_cmd_pkg::OP_CHIP_ERASE: sectorErase_q <= 1'b0;
        // suspend done after the flash's own stop time, polled by the user
        flash_cmd_pkg::OP_SUSPEND: suspended_q <= 1'b1;
        flash_cmd_pkg::OP_RESUME: suspended_q <= 1'b0;
        // reset after erase end clears erase tracking; suspended state survives
        flash_cmd_pkg::OP_RESET: sectorErase_q <= suspended_q;
        default: ;
      endcase
    end
  end
endmodule : flash_bus_command_decoder

//--- testbench/flash_cmd_props.sv
// concurrent checks on the controller's flash pins
`timescale 1ns/1ps
module flash_cmd_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire flash_cmd_pkg::op_t reqOp,
  input wire logic reqReady_q,
  input wire logic rspValid_q,
  input wire logic [21:0] flashAddr,
  input wire logic [15:0] flashDqOut,
  input wire logic flashDqOe,
  input wire logic flashCeN,
  input wire logic flashWeN,
  input wire logic flashOeN
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  strobe_excl_a: assert property (flashWeN || flashOeN)
    else $error("strobes overlap");
  we_with_ce_a: assert property (!flashWeN |-> !flashCeN)
    else $error("write strobe unselected");
  write_drives_a: assert property (!flashWeN |-> flashDqOe)
    else $error("write data undriven");
  read_floats_a: assert property (!flashOeN |-> !flashDqOe)
    else $error("data driven in read");
  strobe_width_a: assert property ($fell(flashCeN) |-> (!flashCeN) [*6])
    else $error("select too short");
  addr_held_a: assert property (!flashCeN && !$past(flashCeN) |-> $stable(flashAddr))
    else $error("address moved");
  data_held_a: assert property ($rose(flashWeN) |-> flashDqOe && $stable(flashDqOut))
    else $error("data not held");
  idle_quiet_a: assert property (reqReady_q |-> flashCeN && flashWeN)
    else $error("strobe while idle");
  rsp_pulse_a: assert property (rspValid_q |=> !rspValid_q)
    else $error("response too long");
  read_start_a: assert property (reqValid && reqReady_q && reqOp == flash_cmd_pkg::OP_READ
    |=> !reqReady_q ##[1:20] !flashOeN)
    else $error("no read strobe");
  write_c: cover property ($rose(flashWeN));
  read_c: cover property ($rose(flashOeN));
  rsp_c: cover property (rspValid_q);
endmodule : flash_cmd_props

//--- testbench/flash_dev_model.sv
// behavioural flash device answering the controller's bus cycles
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] MANUF = 16'h0011, // arbitrary value
  parameter logic [15:0] DEV1 = 16'h0021, // arbitrary value
  parameter logic [15:0] DEV2 = 16'h0022, // arbitrary value
  parameter logic [15:0] DEV3 = 16'h0023, // arbitrary value
  parameter logic [9:0] PROT_SECT = 10'h003,
  parameter logic [15:0] SEC_WORD = 16'h5a5a,
  parameter logic [15:0] CFI_WORD = 16'h0051
) (
  input wire logic [21:0] flashAddr,
  input wire logic [15:0] flashDqOut,
  input wire logic flashCeN,
  input wire logic flashWeN,
  input wire logic flashOeN,
  input wire logic byteMode,
  output logic [15:0] flashDqIn
);
  logic [15:0] mem [logic [21:0]];
  logic [21:0] la;
  logic armed = 1'b0;
  logic ers = 1'b0;
  logic sus = 1'b0;
  logic [9:0] esect = 10'h000;
  logic [15:0] rd;
  logic [15:0] last = 16'h0000;
  logic [7:0] o;
  logic [11:0] u1;
  logic [11:0] u2;
  // 0 array, 1 ident, 2 bypass, 3 secured, 4 query
  int mode = 0;
  int st = 0;
  assign u1 = byteMode ? 12'haaa : 12'h555;
  assign u2 = byteMode ? 12'h555 : 12'h2aa;
  // released bus shows the inverse so a stale sample cannot match
  assign flashDqIn = (!flashCeN && !flashOeN) ? rd : last;
  always @(posedge flashOeN) last = ~rd;
  always @(negedge flashWeN or negedge flashCeN) begin
    if (!flashWeN && !flashCeN) begin
      la = flashAddr;
      armed = 1'b1;
    end
  end
  always @(posedge flashWeN or posedge flashCeN) begin
    if (armed) begin
      armed = 1'b0;
      wr(la, flashDqOut);
    end
  end
  // commands use low data byte and address
  task automatic wr(input logic [21:0] a, input logic [15:0] dw);
    logic [7:0] d;
    logic [11:0] ua;
    d = dw[7:0];
    ua = a[11:0];
    if (st == 9) begin
      mem[a] = dw;
      st = 0;
    end else if (d == 8'hf0 && mode != 2) begin
      mode = (mode == 3) ? 3 : 0;
      st = 0;
    end else if (mode == 2 && st == 0 && d == 8'ha0) st = 9;
    else if (mode == 2 && st == 0 && d == 8'h90) st = 8;
    else if (st == 8 && d == 8'h00) begin
      mode = 0;
      st = 0;
    end else if (st == 0 && d == 8'h98 && ua == (byteMode ? 12'h0aa : 12'h055) && mode < 2) mode = 4;
    else if (st == 0 && d == 8'hb0 && ers && !sus) sus = 1'b1;
    else if (st == 0 && d == 8'h30 && sus) sus = 1'b0;
    else if (d == 8'haa && ua == u1 && (st == 0 || st == 4)) st = st + 1;
    else if (d == 8'h55 && ua == u2 && (st == 1 || st == 5)) st = st + 1;
    else if (st == 2 && ua == u1) begin
      st = 0;
      case (d)
        8'h90: if (mode == 3) st = 8; else mode = 1;
        8'h88: mode = 3;
        8'h20: mode = 2;
        8'ha0: st = 9;
        8'h80: st = 4;
        default: st = 0;
      endcase
    end else if (st == 6 && d == 8'h10 && ua == u1) begin
      mem.delete();
      {ers, sus, st} = 0;
    end else if (st == 6 && d == 8'h30) begin
      esect = a[21:12];
      ers = 1'b1;
      st = 0;
    end else st = 0;
  endtask : wr
  always @* begin
    o = flashAddr[7:0];
    rd = mem.exists(flashAddr) ? mem[flashAddr] : 16'hffff;
    if (ers && flashAddr[21:12] == esect) rd = 16'hffff;
    if (mode == 3) rd = SEC_WORD;
    if (mode == 4) rd = CFI_WORD;
    if (mode == 1) begin
      rd = 16'h0000;
      if (o == 8'h00) rd = MANUF;
      if (o == (byteMode ? 8'h02 : 8'h01)) rd = DEV1;
      if (o == (byteMode ? 8'h1c : 8'h0e)) rd = DEV2;
      if (o == (byteMode ? 8'h1e : 8'h0f)) rd = DEV3;
      if (o == (byteMode ? 8'h06 : 8'h03)) rd = 16'h0080;
      if (o == (byteMode ? 8'h04 : 8'h02)) rd = {15'h0000, flashAddr[21:12] == PROT_SECT};
    end
  end
endmodule : flash_dev_model

//--- testbench/testbench.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  flash_cmd_pkg::op_t reqOp = flash_cmd_pkg::OP_READ;
  flash_cmd_pkg::id_sel_t reqIdSel = flash_cmd_pkg::ID_MANUF;
  logic [21:0] reqAddr = 22'h000000;
  logic [15:0] reqData = 16'h0000;
  logic byteMode = 1'b0;
  logic reqReady_q, rspValid_q, bypassActive_q, securedActive_q, suspended_q;
  logic [15:0] rspData0_q, rspData1_q, rspData2_q, flashDqIn, flashDqOut;
  logic [21:0] flashAddr;
  logic flashDqOe, flashCeN, flashWeN, flashOeN;
  int error_cnt = 0;
  int checked = 0;
  always #5 ref_clk = ~ref_clk;
  flash_bus_command_decoder flash_bus_command_decoder_inst (.ref_clk, .rst_n, .reqValid, .reqOp, .reqIdSel,
    .reqAddr, .reqData, .byteMode, .reqReady_q, .rspValid_q, .rspData0_q, .rspData1_q, .rspData2_q,
    .bypassActive_q, .securedActive_q, .suspended_q, .flashAddr, .flashDqIn, .flashDqOut, .flashDqOe,
    .flashCeN, .flashWeN, .flashOeN);
  flash_dev_model flash_dev_model_inst (.flashAddr, .flashDqOut, .flashCeN, .flashWeN, .flashOeN, .byteMode,
    .flashDqIn);
  // ----
  // helpers
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic fl(input logic f, input logic e);
    chk({15'h0000, f}, {15'h0000, e});
  endtask : fl
  task automatic run(input flash_cmd_pkg::op_t op, input logic [21:0] a, input logic [15:0] d = 16'h0000,
                     input flash_cmd_pkg::id_sel_t s = flash_cmd_pkg::ID_MANUF);
    int n = 0;
    reqValid <= 1'b1;
    reqOp <= op;
    reqAddr <= a;
    reqData <= d;
    reqIdSel <= s;
    do begin
      @(posedge ref_clk);
      n++;
    end while (reqReady_q !== 1'b1 && n < 400);
    reqValid <= 1'b0;
    while (rspValid_q !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 400) chk(16'h0bad, 16'h0000);
  endtask : run
  task automatic refuse(input flash_cmd_pkg::op_t op);
    logic ok = 1'b1;
    reqValid <= 1'b1;
    reqOp <= op;
    repeat (20) begin
      @(posedge ref_clk);
      ok &= (reqReady_q === 1'b1 && flashCeN === 1'b1 && rspValid_q === 1'b0);
    end
    reqValid <= 1'b0;
    @(posedge ref_clk);
    fl(ok, 1'b1);
  endtask : refuse
  task automatic rd(input logic [21:0] a, input logic [15:0] e);
    run(flash_cmd_pkg::OP_READ, a);
    chk(rspData0_q, e);
  endtask : rd
  task automatic idl(input flash_cmd_pkg::id_sel_t s, input logic [21:0] a, input logic [7:0] e);
    run(flash_cmd_pkg::OP_AUTOSEL_READ, a, 16'h0000, s);
    chk(rspData0_q, {8'h00, e});
  endtask : idl
  // ----
  // scenarios
  // ----
  task automatic t_program();
    run(flash_cmd_pkg::OP_PROGRAM, 22'h001234, 16'ha5c3);
    rd(22'h001234, 16'ha5c3);
    rd(22'h001236, 16'hffff);
  endtask : t_program
  task automatic t_ident(input logic bm);
    byteMode <= bm;
    @(posedge ref_clk);
    idl(flash_cmd_pkg::ID_MANUF, 22'h080000, flash_dev_model_inst.MANUF[7:0]);
    idl(flash_cmd_pkg::ID_DEVICE, 22'h080000, flash_dev_model_inst.DEV1[7:0]);
    chk(rspData1_q, flash_dev_model_inst.DEV2 & 16'h00ff);
    chk(rspData2_q, flash_dev_model_inst.DEV3 & 16'h00ff);
    idl(flash_cmd_pkg::ID_FACTLOCK, 22'h080000, 8'h80);
    idl(flash_cmd_pkg::ID_SECTPROT, {flash_dev_model_inst.PROT_SECT, 12'h000}, 8'h01);
    idl(flash_cmd_pkg::ID_SECTPROT, 22'h005000, 8'h00);
    run(flash_cmd_pkg::OP_RESET, 22'h000000);
    rd(22'h001234, 16'ha5c3);
  endtask : t_ident
  task automatic t_bypass();
    refuse(flash_cmd_pkg::OP_BYPASS_PROGRAM);
    run(flash_cmd_pkg::OP_BYPASS_ENTER, 22'h000000);
    fl(bypassActive_q, 1'b1);
    run(flash_cmd_pkg::OP_BYPASS_PROGRAM, 22'h002000, 16'h1357);
    run(flash_cmd_pkg::OP_BYPASS_PROGRAM, 22'h002002, 16'h2468);
    run(flash_cmd_pkg::OP_BYPASS_EXIT, 22'h000000);
    fl(bypassActive_q, 1'b0);
    rd(22'h002000, 16'h1357);
    rd(22'h002002, 16'h2468);
    refuse(flash_cmd_pkg::OP_BYPASS_EXIT);
  endtask : t_bypass
  task automatic t_secured();
    run(flash_cmd_pkg::OP_SECURED_ENTER, 22'h000000);
    fl(securedActive_q, 1'b1);
    rd(22'h000010, flash_dev_model_inst.SEC_WORD);
    run(flash_cmd_pkg::OP_SECURED_EXIT, 22'h000000);
    fl(securedActive_q, 1'b0);
    rd(22'h001234, 16'ha5c3);
  endtask : t_secured
  task automatic t_erase();
    refuse(flash_cmd_pkg::OP_SUSPEND);
    run(flash_cmd_pkg::OP_SECTOR_ERASE, 22'h001000);
    refuse(flash_cmd_pkg::OP_RESUME);
    run(flash_cmd_pkg::OP_SUSPEND, 22'h000000);
    fl(suspended_q, 1'b1);
    rd(22'h002000, 16'h1357);
    run(flash_cmd_pkg::OP_RESUME, 22'h000000);
    fl(suspended_q, 1'b0);
    run(flash_cmd_pkg::OP_CHIP_ERASE, 22'h000000);
    run(flash_cmd_pkg::OP_RESET, 22'h000000);
    rd(22'h002000, 16'hffff);
  endtask : t_erase
  task automatic t_cfi(input logic bm);
    byteMode <= bm;
    @(posedge ref_clk);
    run(flash_cmd_pkg::OP_CFI, 22'h000000);
    rd(22'h000010, flash_dev_model_inst.CFI_WORD);
    run(flash_cmd_pkg::OP_RESET, 22'h000000);
    rd(22'h000010, 16'hffff);
  endtask : t_cfi
  task automatic final_report();
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    fl(reqReady_q, 1'b1);
    fl(flashCeN & flashWeN & flashOeN, 1'b1);
    t_program();
    t_ident(1'b0);
    t_ident(1'b1);
    byteMode <= 1'b0;
    @(posedge ref_clk);
    t_bypass();
    t_secured();
    t_erase();
    t_cfi(1'b0);
    t_cfi(1'b1);
    final_report();
  end
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
endmodule : testbench
bind flash_bus_command_decoder flash_cmd_props flash_cmd_props_inst (.ref_clk, .rst_n, .reqValid, .reqOp,
  .reqReady_q, .rspValid_q, .flashAddr, .flashDqOut, .flashDqOe, .flashCeN, .flashWeN, .flashOeN);
